// ===== rtl/slm_derive.sv
// Mode-derived link parameters shared by both ends
`timescale 1ns/1ps
`include "slm_params.svh"
module slm_derive (
  // Chosen setup
  input  wire logic [3:0] mode,
  input  wire logic       k_long,
  input  wire logic       two_link_flag,
  input  wire logic       scramble,
  input  wire logic       subclass,
  input  wire logic [2:0] version,
  // Derived values
  output slm_pkg::slm_mode_t mode_row,
  output logic [7:0]      k_value,
  output logic            high_density_flag,
  output logic [7:0]      lane_mask,
  output logic [3:0]      dac_power_down_mask,
  output logic            in_phase_to_quadrature_steer,
  output logic [1:0]      pair_gate,
  output logic [7:0]      frames_per_processing_clock,
  output logic [7:0]      processing_clocks_per_multiframe,
  output logic [7:0]      field_sum,
  output logic            combo_ok
);
  import slm_pkg::*;
  // Table lookup and every value derived from it
  always_comb begin
    mode_row = slm_lookup(mode);                                // [RULE_01] [RULE_02]
    k_value = k_long ? `SLM_K_LONG : `SLM_K_SHORT;
    // Short K is not allowed where one octet per frame
    combo_ok = mode_row.valid &&
               (k_long || mode_row.octets != 8'h01);             // [RULE_06] [RULE_24]
    high_density_flag = (mode_row.octets == 8'h01);             // [RULE_04]
    lane_mask = 8'((16'h0001 << mode_row.lanes) - 16'h0001);   // [RULE_10]
    if (mode_row.conv == 8'h01 && !two_link_flag) begin
      dac_power_down_mask = `SLM_PD_M1_SINGLE;                 // [RULE_14]
    end else if (mode_row.conv == 8'h01) begin
      dac_power_down_mask = `SLM_PD_M1_DUAL;
    end else if (mode_row.conv == 8'h02 && !two_link_flag) begin
      dac_power_down_mask = `SLM_PD_M2_SINGLE;
    end else begin
      dac_power_down_mask = `SLM_PD_NONE;
    end
    in_phase_to_quadrature_steer =
      (mode_row.conv == 8'h01) && two_link_flag;                // [RULE_15]
    pair_gate = (dac_power_down_mask[1] && dac_power_down_mask[0]) ?
                `SLM_CLK_GATE_OFF : `SLM_CLK_GATE_ON;            // [RULE_16]
    // Guard against an empty row dividing by zero
    frames_per_processing_clock = (mode_row.octets == 8'h00) ? 8'h00 :
      `SLM_OCTETS_PER_PCLK / mode_row.octets;                   // [RULE_21]
    processing_clocks_per_multiframe =
      (frames_per_processing_clock == 8'h00) ? 8'h00 :
      k_value / frames_per_processing_clock;                    // [RULE_21]
    // Field checksum: both sample-width terms use sixteen minus one
    field_sum = 8'(mode_row.lanes - 8'h01 + mode_row.conv - 8'h01
              + k_value - 8'h01
              + 8'(`SLM_BITS_PER_SAMPLE - 8'h01)
              + 8'(`SLM_BITS_PER_SAMPLE - 8'h01)
              + {7'h00, scramble} + {7'h00, high_density_flag}
              + {7'h00, subclass} + {5'h00, version});           // [RULE_12] [RULE_05]
  end
endmodule : slm_derive

// ===== rtl/slm_dev.sv
// Receiver end: mode registers, derived link setup, lane masks
`timescale 1ns/1ps
`include "slm_params.svh"
// What this block does
// [RULE_01] Modes 0-3: four converters, table values
// [RULE_02] Modes 4-10: two or one converter tables
// [RULE_03] Lane rate is twenty times rate times M/L; no lane rate is computed here, SLM_RATE_MULT is unused
// [RULE_04] High density set when one octet/lane
// [RULE_05] Resolution and sample width are sixteen
// [RULE_06] K must be 32 in modes 0,4,9
// [RULE_07] Two-link flag runs two independent links
// [RULE_08] Descramble only when scrambling flag set
// [RULE_09] Link select steers configuration to link
// [RULE_10] Lane masks are two to L minus one
// [RULE_11] Unused-lane bit set powers lane off
// [RULE_12] Field checksum sums link parameters low byte
// [RULE_13] Register checksum sums packed configuration registers
// [RULE_14] DAC power-down mask from M and links
// [RULE_15] One converter dual link sets steering bit
// [RULE_16] Gate second pair clock when both down
// [RULE_17] Three settings choose lane sampling mode
// [RULE_18] Subclass 0 uses internal clock alignment
// [RULE_19] Subclass 1 needs aligned system reference
// [RULE_20] Delays counted in processing clocks, rate/40
// [RULE_21] Frames per processing_clock and pclocks per multiframe
// [RULE_22] Delay settings align lane release multiframe
// [RULE_23] Link enable 3 dual, 1 single
// [RULE_24] Flag invalid mode and K combinations
module slm_dev #(
  parameter int LINKS = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link port from the transmitter end
  slm_if.dev              port,
  // Per-link resets and lane data control
  input  wire logic [1:0] link_rst_n,
  input  wire logic       sysref_seen,
  input  wire logic [1:0] cdr_select,
  input  wire logic [7:0] delay_setting,
  input  wire logic [7:0] delay_window,
  input  wire logic [7:0] lane_arrival,
  // Derived configuration
  output logic [7:0]      lane_enable_mask,
  output logic [7:0]      lane_power_off,
  output logic [3:0]      dac_power_down_mask,
  output logic            in_phase_to_quadrature_steer,
  output logic [1:0]      link_enable_field,
  output logic [1:0]      descramble_en,
  output logic            high_density_flag,
  output logic            combo_ok,
  output logic            halfrate,
  output logic            oversample_select,
  output logic [1:0]      lane_pll_divider,
  output logic [7:0]      processing_clocks_per_multiframe,
  output logic            lanes_release,
  output logic            pair_sync_internal
);
  import slm_pkg::*;
  // Complete state of the receiver except the sref_s synchronizer
  typedef struct packed {
    logic [7:0] mode_reg;     // scramble, subclass, k_long, mode
    logic [7:0] clk_gate;
    logic [7:0] lane_off;
    logic [7:0] link_ctrl;
    logic [1:0] link_mode;    // per link scramble copy
    logic [7:0] pclk_cnt;     // multiframe phase in processing clocks
    logic       release_q;
  } slm_dreg_t;
  slm_dreg_t r;
  slm_dreg_t next_r;
  slm_mode_t row;
  logic [7:0] kv, lmask, fpc, ppm, fsum, reg_sum;
  logic       hd, steer, ok;
  logic [3:0] pdm;
  logic [1:0] gate;
  logic [7:0] sref_s;
  logic       sel;
  // Derivation shared with the transmitter end
  slm_derive u_derive (
    .mode                             (r.mode_reg[3:0]),
    .k_long                           (r.mode_reg[4]),
    .two_link_flag                    (r.link_ctrl[`SLM_BIT_TWO_LINK]),
    .scramble                         (r.mode_reg[6]),
    .subclass                         (r.mode_reg[5]),
    .version                          (3'h1),
    .mode_row                         (row),
    .k_value                          (kv),
    .high_density_flag                (hd),
    .lane_mask                        (lmask),
    .dac_power_down_mask              (pdm),
    .in_phase_to_quadrature_steer     (steer),
    .pair_gate                        (gate),
    .frames_per_processing_clock      (fpc),
    .processing_clocks_per_multiframe (ppm),
    .field_sum                        (fsum),
    .combo_ok                         (ok)
  );
  // Packed configuration bytes summed as eleven registers
  always_comb begin
    reg_sum = 8'(r.link_ctrl[7:0] + row.lanes + row.conv + row.octets
            + kv + row.samples + `SLM_BITS_PER_SAMPLE
            + `SLM_BITS_PER_SAMPLE + r.mode_reg + {7'h00, hd}
            + 8'h01);                                            // [RULE_13]
  end
  // Register writes, readback and multiframe counter
  always_comb begin
    next_r = r;
    sel = r.link_ctrl[2];                                      // [RULE_09]
    if (port.wr_en) begin
      case (port.addr)
        `SLM_ADDR_MODE:      next_r.mode_reg = port.wdata;
        `SLM_ADDR_CLK_GATE:  next_r.clk_gate = port.wdata;       // [RULE_16]
        `SLM_ADDR_LANE_OFF:  next_r.lane_off = port.wdata;       // [RULE_11]
        `SLM_ADDR_LINK_CTRL: next_r.link_ctrl = port.wdata;
        default: next_r = r;
      endcase
      // Selected link gets the parameters; the other link too only when two-link is set
      if (port.addr == `SLM_ADDR_MODE) begin
        next_r.link_mode[sel] = port.wdata[6];                  // [RULE_07]
        if (r.link_ctrl[`SLM_BIT_TWO_LINK]) begin
          next_r.link_mode[~sel] = port.wdata[6];
        end
      end
    end
    // Count processing clocks around one multiframe
    if (ppm == 8'h00 || r.pclk_cnt >= 8'(ppm - 8'h01)) begin
      next_r.pclk_cnt = 8'h00;                                   // [RULE_20]
    end else begin
      next_r.pclk_cnt = 8'(r.pclk_cnt + 8'h01);
    end
    // Release once all lanes in and delay point inside the window
    next_r.release_q = (&(lane_arrival | ~lmask)) &&
      (r.pclk_cnt >= delay_setting) &&
      (r.pclk_cnt <= 8'(delay_setting + delay_window));         // [RULE_22]
    case (port.addr)
      `SLM_ADDR_MODE:      port.rdata = r.mode_reg;
      `SLM_ADDR_CLK_GATE:  port.rdata = r.clk_gate;
      `SLM_ADDR_LANE_OFF:  port.rdata = r.lane_off;
      `SLM_ADDR_LINK_CTRL: port.rdata = r.link_ctrl;
      `SLM_ADDR_STATUS:    port.rdata =
        r.link_ctrl[`SLM_BIT_CHK_METHOD] ? reg_sum : fsum;       // [RULE_12]
      `SLM_ADDR_DERIVED:   port.rdata = {ok, hd, steer, 1'b0, pdm};
      default:             port.rdata = 8'h00;
    endcase
  end
  // Register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // System reference is a pin: two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sref_s <= 8'h00;
    end else begin
      sref_s <= {sref_s[6:0], sysref_seen};
    end
  end
  assign lane_enable_mask = lmask;                               // [RULE_10]
  assign lane_power_off = r.lane_off;
  assign dac_power_down_mask = pdm;                              // [RULE_14]
  assign in_phase_to_quadrature_steer = steer;                   // [RULE_15]
  assign link_enable_field = r.link_ctrl[1:0];
  // Descramble only on a link out of reset with flag set
  assign descramble_en = r.link_mode & link_rst_n;               // [RULE_08]
  assign high_density_flag = hd;                                 // [RULE_04]
  assign combo_ok = ok;                                          // [RULE_24]
  // Sampling mode decode
  assign halfrate = (cdr_select == SLM_CDR_HALF);                // [RULE_17]
  assign oversample_select = (cdr_select == SLM_CDR_OVER);
  assign lane_pll_divider = (cdr_select == SLM_CDR_OVER) ? 2'h2 :
                            (cdr_select == SLM_CDR_FULL) ? 2'h1 : 2'h0;
  assign processing_clocks_per_multiframe = ppm;                 // [RULE_21]
  // Subclass 1 waits for aligned reference; subclass 0 does not
  assign lanes_release = r.release_q &&
                         (!r.mode_reg[5] || sref_s[1]);           // [RULE_19]
  assign pair_sync_internal = !r.mode_reg[5];                    // [RULE_18]
endmodule : slm_dev

// ===== rtl/slm_host.sv
// Transmitter end: pushes one mode setup into the receiver registers
`timescale 1ns/1ps
`include "slm_params.svh"
module slm_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // User side
  input  wire logic       start,
  input  wire logic [3:0] mode,
  input  wire logic       k_long,
  input  wire logic       two_link_flag,
  input  wire logic       scramble,
  input  wire logic       subclass,
  input  wire logic       checksum_method,
  input  wire logic [7:0] lanes_in_use,
  output logic            busy,
  output logic            done,
  output logic [7:0]      first_lane_checksum,
  // Link
  slm_if.host             port
);
  import slm_pkg::*;
  // Complete state
  typedef struct packed {
    slm_hstate_t st;
    logic [1:0]  step;
    logic        done;
    logic [7:0]  sum;
  } slm_hreg_t;
  slm_hreg_t r;
  slm_hreg_t next_r;
  slm_mode_t row;
  logic [7:0] kv, lmask, fpc, ppm, fsum;
  logic       hd, steer, ok;
  logic [3:0] pdm;
  logic [1:0] gate;
  // Same derivation the receiver uses, so checksums agree
  slm_derive u_derive (
    .mode                             (mode),
    .k_long                           (k_long),
    .two_link_flag                    (two_link_flag),
    .scramble                         (scramble),
    .subclass                         (subclass),
    .version                          (3'h1),
    .mode_row                         (row),
    .k_value                          (kv),
    .high_density_flag                (hd),
    .lane_mask                        (lmask),
    .dac_power_down_mask              (pdm),
    .in_phase_to_quadrature_steer     (steer),
    .pair_gate                        (gate),
    .frames_per_processing_clock      (fpc),
    .processing_clocks_per_multiframe (ppm),
    .field_sum                        (fsum),
    .combo_ok                         (ok)
  );
  // Sequencer: mode, clock gate, lane power, link enable
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    port.wr_en = 1'b0;
    port.addr = `SLM_ADDR_MODE;
    port.wdata = 8'h00;
    case (r.st)
      SLM_IDLE: begin
        if (start) begin
          next_r.st = SLM_WRITE;
          next_r.step = 2'h0;
        end
      end
      SLM_WRITE: begin
        port.wr_en = 1'b1;
        case (r.step)
          2'h0: port.wdata = {1'b0, scramble, subclass, k_long, mode};
          2'h1: begin
            port.addr = `SLM_ADDR_CLK_GATE;
            port.wdata = {gate, 6'h00};                          // [RULE_16]
          end
          2'h2: begin
            port.addr = `SLM_ADDR_LANE_OFF;
            port.wdata = ~lanes_in_use;                          // [RULE_11]
          end
          default: begin
            port.addr = `SLM_ADDR_LINK_CTRL;
            port.wdata = {1'b0, checksum_method, 2'h0, two_link_flag, 1'b0,
              two_link_flag ? `SLM_LINK_EN_DUAL
                            : `SLM_LINK_EN_SINGLE};              // [RULE_23] [RULE_07]
          end
        endcase
        next_r.step = 2'(r.step + 2'h1);
        if (r.step == 2'h3) begin
          next_r.st = SLM_DONE;
        end
      end
      SLM_DONE: begin
        // Capture the receiver's register checksum, or the local field checksum
        next_r.sum = checksum_method ? port.rdata : fsum;        // [RULE_13]
        next_r.done = 1'b1;
        next_r.st = SLM_IDLE;
      end
      default: next_r.st = SLM_IDLE;
    endcase
    if (r.st == SLM_DONE && checksum_method) begin
      port.addr = `SLM_ADDR_STATUS;
    end
  end
  // Register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{SLM_IDLE, 2'h0, 1'b0, 8'h00};
    end else begin
      r <= next_r;
    end
  end
  assign busy = (r.st != SLM_IDLE);
  assign done = r.done;
  assign first_lane_checksum = r.sum;
endmodule : slm_host

// ===== rtl/slm_if.sv
// Configuration port joining the transmitter end and the receiver end
`timescale 1ns/1ps
interface slm_if;
  logic        wr_en;   // Write strobe, one cycle
  logic [11:0] addr;    // Register address
  logic [7:0]  wdata;   // Write data
  logic [7:0]  rdata;   // Read data, for current addr
  modport host (output wr_en, output addr, output wdata, input rdata);
  modport dev  (input wr_en, input addr, input wdata, output rdata);
endinterface : slm_if

// ===== rtl/slm_params.svh
// Constants for the serial link mode configuration block
`ifndef SLM_PARAMS_SVH
`define SLM_PARAMS_SVH
`define SLM_ADDR_CLK_GATE      12'h0080
`define SLM_ADDR_LANE_OFF      12'h0201
`define SLM_ADDR_LINK_CTRL     12'h0300
`define SLM_ADDR_CFG_FIRST     12'h0450
`define SLM_ADDR_CFG_LAST      12'h045A
`define SLM_ADDR_MODE          12'h0470
`define SLM_ADDR_STATUS        12'h0471
`define SLM_ADDR_DERIVED       12'h0472
`define SLM_CFG_REGS           11
`define SLM_BIT_CHK_METHOD     6
`define SLM_BIT_TWO_LINK       3
`define SLM_CLK_GATE_OFF       2'h1
`define SLM_CLK_GATE_ON        2'h0
`define SLM_BITS_PER_SAMPLE    8'h10
`define SLM_K_LONG             8'h20
`define SLM_K_SHORT            8'h10
`define SLM_OCTETS_PER_PCLK    8'h04
`define SLM_LINK_EN_DUAL       2'h3
`define SLM_LINK_EN_SINGLE     2'h1
`define SLM_PD_M1_SINGLE       4'h7
`define SLM_PD_M1_DUAL         4'h6
`define SLM_PD_M2_SINGLE       4'h3
`define SLM_PD_NONE            4'h0
`define SLM_RATE_MULT          8'h14
`define SLM_PCLK_DIV           8'h28
`endif

// ===== rtl/slm_pkg.sv
// Types shared by both ends of the mode configuration link
package slm_pkg;
  // Converter/lane/sample/octet tuple for one mode
  typedef struct packed {
    logic [7:0] conv;
    logic [7:0] lanes;
    logic [7:0] samples;
    logic [7:0] octets;
    logic       valid;
  } slm_mode_t;
  // Lane sampling setting
  typedef enum logic [1:0] {
    SLM_CDR_OVER = 2'b00,
    SLM_CDR_FULL = 2'b01,
    SLM_CDR_HALF = 2'b10
  } slm_cdr_t;
  // Host write sequencer states
  typedef enum logic [1:0] {
    SLM_IDLE = 2'b00,
    SLM_WRITE = 2'b01,
    SLM_DONE = 2'b10
  } slm_hstate_t;
  // Mode table lookup shared by both ends
  function automatic slm_mode_t slm_lookup(input logic [3:0] mode);
    slm_mode_t r;
    r = '{8'h00, 8'h00, 8'h00, 8'h00, 1'b1};
    case (mode)
      4'h0: r = '{8'h04, 8'h08, 8'h01, 8'h01, 1'b1};
      4'h1: r = '{8'h04, 8'h08, 8'h02, 8'h02, 1'b1};
      4'h2: r = '{8'h04, 8'h04, 8'h01, 8'h02, 1'b1};
      4'h3: r = '{8'h04, 8'h02, 8'h01, 8'h04, 1'b1};
      4'h4: r = '{8'h02, 8'h04, 8'h01, 8'h01, 1'b1};
      4'h5: r = '{8'h02, 8'h04, 8'h02, 8'h02, 1'b1};
      4'h6: r = '{8'h02, 8'h02, 8'h01, 8'h02, 1'b1};
      4'h7: r = '{8'h02, 8'h01, 8'h01, 8'h04, 1'b1};
      4'h9: r = '{8'h01, 8'h02, 8'h01, 8'h01, 1'b1};
      4'hA: r = '{8'h01, 8'h01, 8'h01, 8'h02, 1'b1};
      default: r = '{8'h00, 8'h00, 8'h00, 8'h00, 1'b0};
    endcase
    return r;
  endfunction : slm_lookup
endpackage : slm_pkg

// ===== tb/slm_sva.sv
// Checker for the configuration port joining the two ends
`timescale 1ns/1ps
`include "slm_params.svh"
module slm_sva (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration port
  input  wire logic        wr_en,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] seen_mode;  // Mode nibble of the setup in flight
  logic [1:0] seen_gate;  // Gate field of the setup in flight
  logic       w_mode;     // Mode register write
  logic       w_gate;     // Clock gate write
  logic       w_lane;     // Lane power-off write
  logic       w_link;     // Link control write
  assign w_mode = wr_en && addr == `SLM_ADDR_MODE;
  assign w_gate = wr_en && addr == `SLM_ADDR_CLK_GATE;
  assign w_lane = wr_en && addr == `SLM_ADDR_LANE_OFF;
  assign w_link = wr_en && addr == `SLM_ADDR_LINK_CTRL;
  // Gate is only known good once the link flag arrives, so keep both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_mode <= 4'h0;
      seen_gate <= 2'h0;
    end else begin
      if (w_mode) seen_mode <= wdata[3:0];
      if (w_gate) seen_gate <= wdata[7:6];
    end
  end
  // Second pair may idle only when DAC2 and DAC3 are both off
  function automatic logic [1:0] gate_for(input logic [3:0] m,
                                          input logic       dual);
    logic few;
    few = (m >= 4'h4 && m <= 4'h7) || m == 4'h9 || m == 4'hA;
    return (few && !dual) ? `SLM_CLK_GATE_OFF : `SLM_CLK_GATE_ON;
  endfunction : gate_for
  property p_mode_then_gate; w_mode |=> w_gate; endproperty
  a_mode_then_gate: assert property (p_mode_then_gate)
    else $error("gate write did not follow mode write");
  property p_gate_then_lane; w_gate |=> w_lane; endproperty
  a_gate_then_lane: assert property (p_gate_then_lane)
    else $error("lane write did not follow gate write");
  property p_lane_then_link; w_lane |=> w_link; endproperty
  a_lane_then_link: assert property (p_lane_then_link)
    else $error("link write did not follow lane write");
  property p_link_enable;
    w_link |-> wdata[1:0] ==
      (wdata[`SLM_BIT_TWO_LINK] ? `SLM_LINK_EN_DUAL : `SLM_LINK_EN_SINGLE);
  endproperty
  a_link_enable: assert property (p_link_enable)
    else $error("link enable field wrong for link count");
  property p_gate_value;
    w_link |-> seen_gate == gate_for(seen_mode, wdata[`SLM_BIT_TWO_LINK]);
  endproperty
  a_gate_value: assert property (p_gate_value)
    else $error("pair clock gate wrong for mode");
  property p_reg_checksum_read;
    w_link && wdata[`SLM_BIT_CHK_METHOD] |=>
      !wr_en && addr == `SLM_ADDR_STATUS;
  endproperty
  a_reg_checksum_read: assert property (p_reg_checksum_read)
    else $error("checksum readback address not presented");
  property p_quiet_after; w_link |=> !wr_en [*2]; endproperty
  a_quiet_after: assert property (p_quiet_after)
    else $error("stray write after link control");
  property p_burst_start; $rose(wr_en) |-> w_mode; endproperty
  a_burst_start: assert property (p_burst_start)
    else $error("write burst did not open with mode");
  c_dual: cover property (w_link && wdata[`SLM_BIT_TWO_LINK]);
  c_single: cover property (w_link && !wdata[`SLM_BIT_TWO_LINK]);
  c_regsum: cover property (w_link && wdata[`SLM_BIT_CHK_METHOD]);
endmodule : slm_sva

// ===== tb/slm_tb.sv
// Self-checking bench: host end drives device end across the port
`timescale 1ns/1ps
module slm_tb;
  import slm_pkg::*;
  // Expected outcome of one setup
  typedef struct {
    logic       ok, valid, scr, steer, hd, chk, hr, ov, psi;
    logic [7:0] lem, off, ppm, sum;
    logic [3:0] pdm;
    logic [1:0] len, div;
  } slm_exp_t;
  logic       clk, rst_n, start, k_long, two_link_flag, scramble;
  logic       subclass, checksum_method, busy, done, sysref_seen;
  logic [3:0] mode, dac_power_down_mask;
  logic [7:0] lanes_in_use, first_lane_checksum, delay_setting;
  logic [7:0] delay_window, lane_arrival, lane_enable_mask;
  logic [7:0] lane_power_off, processing_clocks_per_multiframe;
  logic [1:0] cdr_select, link_enable_field, descramble_en;
  logic [1:0] lane_pll_divider, link_rst_n;
  logic       in_phase_to_quadrature_steer, high_density_flag, combo_ok;
  logic       halfrate, oversample_select, lanes_release;
  logic       pair_sync_internal;
  int         mismatches, comparisons, seed;
  slm_exp_t   exp_q[$];   // Notes from the driver, oldest first
  slm_if slm_if_i ();
  slm_host slm_host_i (.clk(clk), .rst_n(rst_n), .start(start),
    .mode(mode), .k_long(k_long), .two_link_flag(two_link_flag),
    .scramble(scramble), .subclass(subclass),
    .checksum_method(checksum_method), .lanes_in_use(lanes_in_use),
    .busy(busy), .done(done), .first_lane_checksum(first_lane_checksum),
    .port(slm_if_i.host));
  slm_dev slm_dev_i (.clk(clk), .rst_n(rst_n), .port(slm_if_i.dev),
    .link_rst_n(link_rst_n), .sysref_seen(sysref_seen),
    .cdr_select(cdr_select),
    .delay_setting(delay_setting), .delay_window(delay_window),
    .lane_arrival(lane_arrival), .lane_enable_mask(lane_enable_mask),
    .lane_power_off(lane_power_off),
    .dac_power_down_mask(dac_power_down_mask),
    .in_phase_to_quadrature_steer(in_phase_to_quadrature_steer),
    .link_enable_field(link_enable_field), .descramble_en(descramble_en),
    .high_density_flag(high_density_flag), .combo_ok(combo_ok),
    .halfrate(halfrate), .oversample_select(oversample_select),
    .lane_pll_divider(lane_pll_divider),
    .processing_clocks_per_multiframe(processing_clocks_per_multiframe),
    .lanes_release(lanes_release), .pair_sync_internal(pair_sync_internal));
  slm_sva slm_sva_i (.clk(clk), .rst_n(rst_n), .wr_en(slm_if_i.wr_en),
    .addr(slm_if_i.addr), .wdata(slm_if_i.wdata), .rdata(slm_if_i.rdata));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Converters, lanes and octets per lane for each mode; zero if absent
  function automatic logic [11:0] row(input logic [3:0] m);
    case (m)
      4'h0: return 12'h481;
      4'h1: return 12'h482;
      4'h2: return 12'h442;
      4'h3: return 12'h424;
      4'h4: return 12'h241;
      4'h5: return 12'h242;
      4'h6: return 12'h222;
      4'h7: return 12'h214;
      4'h9: return 12'h121;
      4'hA: return 12'h112;
      default: return 12'h000;
    endcase
  endfunction : row
  // One comparison, counted, reported at once on a miss
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // Counts, verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // One setup pushed through; a second start while busy must be ignored
  task automatic run(input logic [3:0] m, input logic kl, input logic dl);
    logic [11:0] r;
    logic [7:0]  kv, mc, lc, fc;
    slm_exp_t    e;
    int          n;
    @(posedge clk);
    #1;
    r = row(m);
    mc = 8'(r[11:8]);
    lc = 8'(r[7:4]);
    fc = 8'(r[3:0]);
    mode = m;
    k_long = kl;
    two_link_flag = dl;
    scramble = 1'($random(seed));
    subclass = 1'($random(seed));
    checksum_method = 1'($random(seed));
    lanes_in_use = 8'($random(seed));
    cdr_select = 2'($unsigned($random(seed)) % 3);
    sysref_seen = 1'($random(seed));
    delay_setting = 8'($random(seed));
    delay_window = 8'($random(seed));
    lane_arrival = 8'($random(seed));
    link_rst_n = 2'($random(seed));
    kv = kl ? 8'h20 : 8'h10;
    e.valid = r != 12'h000;
    e.ok = e.valid && (kl || !(m == 4'h0 || m == 4'h4 || m == 4'h9));
    e.lem = 8'((9'h001 << lc) - 9'h001);
    e.off = ~lanes_in_use;
    e.pdm = mc == 8'h01 ? (dl ? 4'h6 : 4'h7) :
            (mc == 8'h02 && !dl) ? 4'h3 : 4'h0;
    e.steer = mc == 8'h01 && dl;
    e.len = dl ? 2'h3 : 2'h1;
    e.hd = fc == 8'h01;
    e.scr = scramble & link_rst_n[0];
    e.ppm = 8'((16'(kv) * 16'(fc)) >> 2);
    // Lanes-1, M-1, K-1, two sample widths of 15, version 1
    e.sum = lc + mc + kv + 8'h1C + 8'(scramble) + 8'(e.hd) + 8'(subclass);
    e.chk = !checksum_method;
    e.hr = cdr_select == 2'h2;
    e.ov = cdr_select == 2'h0;
    e.div = 2'h2 - cdr_select;
    e.psi = !subclass;
    exp_q.push_back(e);
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    @(posedge clk);
    #1 start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: setup hung", $time);
      tally_and_finish();
    end
    $display("test %0d %0d %0d ended", m, kl, dl);
  endtask : run
  // Watcher: each done takes the oldest note and compares
  always @(negedge clk) begin : watch
    slm_exp_t e;
    if (rst_n === 1'b1 && done === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED at %0t: stray done", $time);
      end else begin
        e = exp_q.pop_front();
        check(8'(combo_ok), 8'(e.ok));
        if (e.valid) begin
          check(lane_enable_mask, e.lem);
          check(lane_power_off, e.off);
          check(8'(dac_power_down_mask), 8'(e.pdm));
          check(8'(in_phase_to_quadrature_steer), 8'(e.steer));
          check(8'(link_enable_field), 8'(e.len));
          check(8'(high_density_flag), 8'(e.hd));
          check(processing_clocks_per_multiframe, e.ppm);
          check(8'(descramble_en[0]), 8'(e.scr));
          check(8'({halfrate,oversample_select}),8'({e.hr,e.ov}));
          check(8'(lane_pll_divider), 8'(e.div));
          check(8'(pair_sync_internal), 8'(e.psi));
          if (~&(lane_arrival | ~e.lem) || (subclass && !sysref_seen))
            check(8'(lanes_release), 8'h00);
          if (e.chk) check(first_lane_checksum, e.sum);
        end
      end
    end
  end
  // Main sequence: reset, then modes 0 to 11, each K choice and link count
  initial begin
    seed = 19703;
    mismatches = 0;
    comparisons = 0;
    {rst_n, start, mode, k_long, two_link_flag, scramble} = '0;
    {subclass, checksum_method, lanes_in_use, sysref_seen} = '0;
    {cdr_select, delay_setting, delay_window, lane_arrival} = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check(8'(link_enable_field), 8'h00);
    for (int m = 0; m < 12; m++) begin
      for (int c = 0; c < 4; c++) begin
        run(4'(m), c[0], c[1]);
      end
    end
    repeat (4) @(posedge clk);
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule : slm_tb
